// File: tpgc_defs.svh
// Constants of the three-pin I/O configuration block: register address,
// field positions, reset value and command codes.
// Assumes inclusion by bare name from every file that needs them.
`ifndef TPGC_DEFS_SVH
`define TPGC_DEFS_SVH

// =====================================================================
// Register map
`define TPGC_CFG_ADDR      3'h4
`define TPGC_CFG_RESET     8'h00
`define TPGC_CFG_WMASK     8'h7F

// =====================================================================
// Field positions of the I/O configuration register
`define TPGC_BIT_RSVD      7
`define TPGC_BIT_DIR0      4
`define TPGC_BIT_SEL2      3

// =====================================================================
// Serial command set
`define TPGC_SYNC_WORD     8'h55
`define TPGC_CMD_WREG      4'h4
`define TPGC_CMD_RREG      4'h2
`define TPGC_CMD_RESET     8'h06

// =====================================================================
// Autobaud: falling edges of the sync word after its first; it spans eight
// bit times between its first and fifth falling edge; the shift divides by eight
`define TPGC_SYNC_FALLS    3'h4
`define TPGC_SYNC_SHIFT    3

`endif

// File: tpgc_pkg.sv
// Types shared by the I/O configuration block and its serial engine.
// Assumes tpgc_defs.svh holds all numeric constants.
package tpgc_pkg;

    // =================================================================
    // Serial engine states
    typedef enum logic [1:0] {
        U_IDLE = 2'b00,
        U_SYNC = 2'b01,
        U_RX   = 2'b10,
        U_TX   = 2'b11
    } tpgc_ustate_t;

    // =================================================================
    // Command parser states
    typedef enum logic [1:0] {
        P_SYNC  = 2'b00,
        P_CMD   = 2'b01,
        P_WDATA = 2'b10,
        P_TX    = 2'b11
    } tpgc_pstate_t;

    // =================================================================
    // Received byte from the serial engine
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tpgc_rx_t;

    // =================================================================
    // Pin drive towards the pads
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe_n;
    } tpgc_pins_t;

    // =================================================================
    // Whole state of the top module
    typedef struct packed {
        tpgc_pstate_t pst;
        logic [7:0]   cfg;
        logic [2:0]   addr;
        logic         tx_go;
        logic [7:0]   tx_data;
        logic         ready;
        logic         rx_m;
        logic         rx_s;
        logic [2:0]   pin_m;
        logic [2:0]   pin_s;
        tpgc_pins_t   pins;
        logic [7:0]   rd;
    } tpgc_state_t;

endpackage : tpgc_pkg

// File: tpgc_uart.sv
// Half-duplex 8-N-1 serial engine with autobaud from the sync word.
// Assumes i_rx is already synchronised to i_clk.
`timescale 1ns/100ps
`include "tpgc_defs.svh"

module tpgc_uart #(
    parameter int CNT_W = 20
) (
    // Clock, reset and enable
    input  wire logic           i_clk,
    input  wire logic           i_rst,
    input  wire logic           i_ce,
    // Serial line
    input  wire logic           i_rx,
    output logic                o_tx,
    // Control
    input  wire logic           i_sync_mode,
    input  wire logic           i_tx_start,
    input  wire logic [7:0]     i_tx_data,
    output logic                o_tx_busy,
    output logic                o_sync_done,
    output tpgc_pkg::tpgc_rx_t  o_rx
);

    // =================================================================
    // Parameter check
    if (CNT_W < 8 || CNT_W > 31) begin : g_chk
        $error("tpgc_uart: CNT_W must lie in 8..31");
    end

    // =================================================================
    // State
    typedef struct packed {
        tpgc_pkg::tpgc_ustate_t st;
        logic [CNT_W-1:0]       cnt;
        logic [CNT_W-1:0]       period;
        logic [3:0]             bitn;
        logic [2:0]             edges;
        logic [9:0]             sh;
        logic                   prev;
        logic                   txl;
        logic                   sync_done;
        tpgc_pkg::tpgc_rx_t     rx;
    } tpgc_ust_t;

    tpgc_ust_t q;
    tpgc_ust_t d;
    logic      fall;

    always_comb begin
        d           = q;
        d.sync_done = 1'b0;
        d.rx.valid  = 1'b0;
        d.prev      = i_rx;
        fall        = q.prev & ~i_rx;
        case (q.st)
            tpgc_pkg::U_IDLE: begin
                d.txl = 1'b1;
                if (i_tx_start) begin
                    d.st   = tpgc_pkg::U_TX;
                    d.sh   = {1'b1, i_tx_data, 1'b0};
                    d.txl  = 1'b0;
                    d.cnt  = q.period - 1'b1;
                    d.bitn = 4'h9;
                end else if (fall) begin
                    if (i_sync_mode) begin
                        d.st    = tpgc_pkg::U_SYNC;
                        d.cnt   = '0;
                        d.edges = 3'h1;
                    end else begin
                        d.st   = tpgc_pkg::U_RX;
                        d.cnt  = q.period >> 1;
                        d.bitn = 4'h0;
                    end
                end
            end
            tpgc_pkg::U_SYNC: begin
                // Alternating bits of the sync word give a falling edge
                // every second bit time
                d.cnt = q.cnt + 1'b1;
                if (fall) begin
                    if (q.edges == `TPGC_SYNC_FALLS) begin
                        d.period    = CNT_W'(({1'b0, q.cnt} + 1'b1)
                                      >> `TPGC_SYNC_SHIFT);
                        d.sync_done = 1'b1;
                        d.st        = tpgc_pkg::U_IDLE;
                    end else begin
                        d.edges = q.edges + 1'b1;
                    end
                end else if (&q.cnt) begin
                    d.st = tpgc_pkg::U_IDLE;
                end
            end
            tpgc_pkg::U_RX: begin
                if (q.cnt == '0) begin
                    d.cnt  = q.period - 1'b1;
                    d.bitn = q.bitn + 1'b1;
                    if (q.bitn == 4'h0 && i_rx) begin
                        d.st = tpgc_pkg::U_IDLE;
                    end else if (q.bitn == 4'h9) begin
                        d.st       = tpgc_pkg::U_IDLE;
                        d.rx.valid = i_rx;
                        d.rx.data  = q.sh[7:0];
                    end else if (q.bitn != 4'h0) begin
                        d.sh = {q.sh[9:8], i_rx, q.sh[7:1]};
                    end
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            tpgc_pkg::U_TX: begin
                if (q.cnt == '0) begin
                    d.cnt = q.period - 1'b1;
                    if (q.bitn == 4'h0) begin
                        d.st  = tpgc_pkg::U_IDLE;
                        d.txl = 1'b1;
                    end else begin
                        d.sh   = {1'b1, q.sh[9:1]};
                        d.txl  = q.sh[1];
                        d.bitn = q.bitn - 1'b1;
                    end
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default: d.st = tpgc_pkg::U_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q        <= '0;
            q.period <= CNT_W'(1);
            q.prev   <= 1'b1;
            q.txl    <= 1'b1;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_tx        = q.txl;
    assign o_tx_busy   = (q.st == tpgc_pkg::U_TX);
    assign o_sync_done = q.sync_done;
    assign o_rx        = q.rx;

endmodule : tpgc_uart

// File: tpgc_top.sv
// Three general-purpose I/O pins under one configuration register,
// reached over a serial command port with a sync word per command.
// Assumes pads resolve level from out and oe_n, and the converter
// datapath pulses result-new and result-read on i_clk.
//
// Function
// - I/O configuration register sits at address 04h, resets to 00h.
// - Bit 7 is reserved, reads zero; host writes zero there.
// - Bit 6 sets pin 2 direction: 0 input (default), 1 output.
// - Bit 5 sets pin 1 direction: 0 input (default), 1 output.
// - Bit 4 sets pin 0 direction: 0 input (default), 1 output.
// - Bit 3 picks pin 2 source when output: level bit or ready flag.
// - Bit 2 drives pin 2 as output, shows its sampled level as input.
// - Bit 1 drives pin 1 as output, shows its sampled level as input.
// - Bit 0 drives pin 0 as output, shows its sampled level as input.
// - Each command follows a sync word; baud rate comes from it.
// - Ready flag sets on a new result, clears when data are read.
// - Pin 2 carrying the ready flag goes low when data are ready.
`timescale 1ns/100ps
`include "tpgc_defs.svh"

module tpgc_top #(
    parameter int CNT_W = 20
) (
    // Clock, reset, enable
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    input  wire logic            i_ce,
    // Serial command port
    input  wire logic            i_rx,
    output logic                 o_tx,
    // I/O pins
    input  wire logic [2:0]      i_pin_in,
    output tpgc_pkg::tpgc_pins_t o_pins,
    // Converter datapath
    input  wire logic            i_result_new,
    input  wire logic            i_result_read,
    output logic                 o_conversion_ready,
    // Register readback
    output logic [7:0]           o_config
);

    // =================================================================
    // Readback: input pins show their sampled level
    function automatic logic [7:0] cfg_read(input logic [7:0] cfg,
                                            input logic [2:0] pin);
        logic [7:0] r;
        r                 = cfg;
        r[`TPGC_BIT_RSVD] = 1'b0;
        for (int i = 0; i < 3; i++) begin
            r[i] = cfg[`TPGC_BIT_DIR0 + i] ? cfg[i] : pin[i];
        end
        return r;
    endfunction : cfg_read

    // =================================================================
    // State and serial engine
    tpgc_pkg::tpgc_state_t q;
    tpgc_pkg::tpgc_state_t d;
    tpgc_pkg::tpgc_rx_t    rx;
    logic                  sync_done;
    logic                  tx_busy;
    logic [7:0]            cmd;
    logic                  to_ready;

    tpgc_uart #(
        .CNT_W       (CNT_W)
    ) u_uart (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_rx        (q.rx_s),
        .o_tx        (o_tx),
        .i_sync_mode (q.pst == tpgc_pkg::P_SYNC),
        .i_tx_start  (q.tx_go),
        .i_tx_data   (q.tx_data),
        .o_tx_busy   (tx_busy),
        .o_sync_done (sync_done),
        .o_rx        (rx)
    );

    assign cmd = rx.data;

    // =================================================================
    // Next state
    always_comb begin
        d       = q;
        d.tx_go = 1'b0;
        // Two-stage synchronisers for everything that enters from pads
        d.rx_m  = i_rx;
        d.rx_s  = q.rx_m;
        d.pin_m = i_pin_in;
        d.pin_s = q.pin_m;
        // A new result in the same cycle as a read keeps the flag set
        d.ready = i_result_new | (q.ready & ~i_result_read);

        case (q.pst)
            tpgc_pkg::P_SYNC: begin
                // Every command must be preceded by a fresh sync word
                if (sync_done) begin
                    d.pst = tpgc_pkg::P_CMD;
                end
            end
            tpgc_pkg::P_CMD: begin
                if (rx.valid) begin
                    d.pst = tpgc_pkg::P_SYNC;
                    if (cmd[7:4] == `TPGC_CMD_WREG) begin
                        d.addr = cmd[3:1];
                        d.pst  = tpgc_pkg::P_WDATA;
                    end else if (cmd[7:4] == `TPGC_CMD_RREG) begin
                        // Other addresses belong to other blocks
                        d.tx_data = (cmd[3:1] == `TPGC_CFG_ADDR) ?
                                    cfg_read(q.cfg, q.pin_s) : 8'h00;
                        d.tx_go   = 1'b1;
                        d.pst     = tpgc_pkg::P_TX;
                    end else if (cmd == `TPGC_CMD_RESET) begin
                        d.cfg = `TPGC_CFG_RESET;
                    end
                end
            end
            tpgc_pkg::P_WDATA: begin
                if (rx.valid) begin
                    if (q.addr == `TPGC_CFG_ADDR) begin
                        d.cfg = rx.data & `TPGC_CFG_WMASK;
                    end
                    d.pst = tpgc_pkg::P_SYNC;
                end
            end
            tpgc_pkg::P_TX: begin
                if (!q.tx_go && !tx_busy) begin
                    d.pst = tpgc_pkg::P_SYNC;
                end
            end
            default: d.pst = tpgc_pkg::P_SYNC;
        endcase

        // Pin drive; enables are active low
        for (int i = 0; i < 3; i++) begin
            d.pins.oe_n[i] = ~q.cfg[`TPGC_BIT_DIR0 + i];
            d.pins.out[i]  = q.cfg[i];
        end
        if (q.cfg[`TPGC_BIT_SEL2]) begin
            d.pins.out[2] = ~q.ready;
        end
        d.rd = cfg_read(q.cfg, q.pin_s);
    end

    // =================================================================
    // Registers; reset wins over the clock enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q           <= '0;
            q.cfg       <= `TPGC_CFG_RESET;
            q.rx_m      <= 1'b1;
            q.rx_s      <= 1'b1;
            q.pins.oe_n <= 3'h7;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_pins             = q.pins;
    assign o_conversion_ready = q.ready;
    assign o_config           = q.rd;

    // =================================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_RESET_ZERO: assert property (
        $past(i_rst) |-> (q.cfg == 8'h00 && o_pins.oe_n == 3'h7))
        else $error("config not cleared by reset");

    AST_RSVD_ZERO: assert property (
        o_config[7] == 1'b0 && q.cfg[7] == 1'b0)
        else $error("reserved bit not zero");

    AST_DIR2: assert property (
        $past(i_ce) |-> o_pins.oe_n[2] == !$past(q.cfg[6]))
        else $error("pin 2 direction wrong");

    AST_DIR1: assert property (
        $past(i_ce) |-> o_pins.oe_n[1] == !$past(q.cfg[5]))
        else $error("pin 1 direction wrong");

    AST_DIR0: assert property (
        $past(i_ce) |-> o_pins.oe_n[0] == !$past(q.cfg[4]))
        else $error("pin 0 direction wrong");

    AST_READY_PIN: assert property (
        $past(i_ce && q.cfg[6] && q.cfg[3])
        |-> o_pins.out[2] == !$past(q.ready))
        else $error("pin 2 not following ready flag");

    AST_LEVEL2: assert property (
        $past(i_ce && !q.cfg[3]) |-> o_pins.out[2] == $past(q.cfg[2]))
        else $error("pin 2 level wrong");

    AST_LEVEL1: assert property (
        $past(i_ce) |-> o_pins.out[1] == $past(q.cfg[1]))
        else $error("pin 1 level wrong");

    AST_LEVEL0: assert property (
        $past(i_ce) |-> o_pins.out[0] == $past(q.cfg[0]))
        else $error("pin 0 level wrong");

    AST_IN2_READ: assert property (
        $past(i_ce && !q.cfg[6]) |-> o_config[2] == $past(q.pin_s[2]))
        else $error("pin 2 readback wrong");

    AST_OUT2_READ: assert property (
        $past(i_ce && q.cfg[6]) |-> o_config[2] == $past(q.cfg[2]))
        else $error("pin 2 output readback wrong");

    AST_IN1_READ: assert property (
        $past(i_ce && !q.cfg[5]) |-> o_config[1] == $past(q.pin_s[1]))
        else $error("pin 1 readback wrong");

    AST_IN0_READ: assert property (
        $past(i_ce && !q.cfg[4]) |-> o_config[0] == $past(q.pin_s[0]))
        else $error("pin 0 readback wrong");

    AST_SYNC_FIRST: assert property (
        i_ce && q.pst == tpgc_pkg::P_SYNC && !sync_done
        |=> q.pst == tpgc_pkg::P_SYNC)
        else $error("command taken without sync word");

    AST_READY_SET: assert property (
        $past(i_ce && i_result_new) |-> o_conversion_ready)
        else $error("ready flag missed a result");

    AST_READY_CLR: assert property (
        $past(i_ce && i_result_read && !i_result_new)
        |-> !o_conversion_ready)
        else $error("ready flag not cleared by read");

    // Judged one cycle on, so a read or a rewrite after that is no fault
    AST_READY_LOW: assert property (
        i_ce && q.cfg[6] && q.cfg[3] && q.ready
        |=> !o_pins.oe_n[2] && !o_pins.out[2])
        else $error("pin 2 not low with ready data");

    AST_INPUT_HIZ: assert property (
        $past(i_ce && q.cfg[6:4] == 3'h0) |-> o_pins.oe_n == 3'h7)
        else $error("driver on for an input pin");

    COV_SYNC: cover property (sync_done ##[1:1000] rx.valid);
    COV_WRITE: cover property (
        q.pst == tpgc_pkg::P_WDATA && rx.valid
        && q.addr == `TPGC_CFG_ADDR);
    COV_READ: cover property (q.tx_go ##1 tx_busy);
    COV_READY_PIN: cover property (
        o_pins.oe_n[2] == 1'b0 && o_pins.out[2] == 1'b0 && q.cfg[3]);

endmodule : tpgc_top

// File: tpgc_host_model.sv
// Host microcontroller and board model for the three-pin I/O block.
// Assumes the device samples its serial input after a 2-flop sync and
// that the board drives a pad only while the device releases it.
`timescale 1ns/100ps
`include "tpgc_defs.svh"

module tpgc_host_model (
    // Clock
    input  wire logic                 i_clk,
    // Serial lines, named from the device side
    input  wire logic                 i_tx,
    output logic                      o_rx,
    // Pads
    input  wire tpgc_pkg::tpgc_pins_t i_pins,
    input  wire logic [2:0]           i_board,
    output logic [2:0]                o_pin_in
);
    // =================================================================
    // Bit period in clock cycles, changed by the bench between commands
    int unsigned period = 32;

    initial o_rx = 1'b1;

    // =================================================================
    // Pad resolution: a driven pad shows the device, a released one
    // shows the board
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            o_pin_in[i] = i_pins.oe_n[i] ? i_board[i]
                                         : i_pins.out[i];
        end
    end

    // =================================================================
    // Serial helpers; every action lands just after a rising edge
    task automatic tick(input int unsigned k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rx = frame[i];
            tick(period);
        end
    endtask : send_byte

    // Bounded wait for the start bit; returns in mid stop bit
    task automatic recv_byte(output logic [7:0] b, output bit ok);
        int unsigned n;
        ok = 1'b0;
        b  = 8'h00;
        n  = 0;
        while (i_tx !== 1'b0 && n < 40 * period) begin
            tick(1);
            n++;
        end
        if (i_tx !== 1'b0) return;
        tick(period / 2);
        for (int i = 0; i < 8; i++) begin
            tick(period);
            b[i] = i_tx;
        end
        tick(period);
        ok = (i_tx === 1'b1);
    endtask : recv_byte

    // Sync word ahead of every command, then command and data
    task automatic command(input logic [7:0] cmd, input logic [7:0] data,
                           input bit wr, input bit rd,
                           output logic [7:0] ans, output bit ok);
        ans = 8'h00;
        ok  = 1'b1;
        send_byte(`TPGC_SYNC_WORD);
        if (rd) begin
            fork
                send_byte(cmd);
                recv_byte(ans, ok);
            join
            tick(period);
        end else begin
            send_byte(cmd);
        end
        if (wr) begin
            send_byte(data);
        end
    endtask : command

endmodule : tpgc_host_model

// File: tb_top.sv
// Self-checking bench for the three-pin I/O configuration block.
// Assumes tpgc_host_model stands in for the host and the board.
`timescale 1ns/100ps

module tb_top;
    logic                 clk;
    logic                 rst;
    logic                 rx;
    logic                 tx;
    logic [2:0]           pin_in;
    logic [2:0]           board;
    tpgc_pkg::tpgc_pins_t pins;
    logic                 res_new;
    logic                 res_read;
    logic                 rdy;
    logic                 ce;
    logic [7:0]           cfg;
    int                   mismatches = 0;
    int                   cmp_count = 0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    tpgc_top #(.CNT_W(20)) tpgc_top_inst (
        .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_rx(rx), .o_tx(tx),
        .i_pin_in(pin_in), .o_pins(pins), .i_result_new(res_new),
        .i_result_read(res_read), .o_conversion_ready(rdy), .o_config(cfg)
    );

    tpgc_host_model tpgc_host_model_inst (
        .i_clk(clk), .i_tx(tx), .o_rx(rx), .i_pins(pins),
        .i_board(board), .o_pin_in(pin_in)
    );

    // =================================================================
    // Shared helpers
    task automatic tick(input int unsigned k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic final_report();
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic write_reg(input logic [7:0] v);
        logic [7:0] a;
        bit         ok;
        tpgc_host_model_inst.command(8'h48, v, 1'b1, 1'b0, a, ok);
        tick(6);
    endtask : write_reg

    task automatic read_reg(input logic [2:0] addr, input logic [7:0] exp);
        logic [7:0] a;
        bit         ok;
        tpgc_host_model_inst.command({4'h2, addr, 1'b0}, 8'h00, 1'b0, 1'b1,
                                     a, ok);
        if (!ok) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
            final_report();
        end
        chk(a, exp);
    endtask : read_reg

    // =================================================================
    // Scenarios
    task automatic t_reset();
        chk(cfg, 8'h00);
        chk({2'b00, pins}, 8'h07);
        chk({7'h00, rdy}, 8'h00);
        read_reg(3'h4, 8'h00);
    endtask : t_reset

    task automatic t_reserved();
        write_reg(8'hFF);
        chk(cfg, 8'h7F);
        chk({2'b00, pins}, 8'h38);
        read_reg(3'h4, 8'h7F);
    endtask : t_reserved

    // Stored level is set opposite to the board, so a leak shows
    task automatic t_directions();
        logic [7:0] tbl [5] = '{8'h45, 8'h22, 8'h11, 8'h75, 8'h00};
        logic [7:0] d;
        logic [7:0] e;
        foreach (tbl[i]) begin
            board = ~tbl[i][2:0];
            write_reg(tbl[i]);
            d = {5'h00, tbl[i][6:4]};
            e = (tbl[i] & 8'h78) | (tbl[i] & d) | ({5'h00, board} & ~d);
            chk(8'(pins.oe_n), d ^ 8'h07);
            chk(pins.out & d, tbl[i] & d);
            chk(cfg, e);
        end
    endtask : t_directions

    task automatic t_inputs();
        write_reg(8'h00);
        for (int b = 0; b < 8; b++) begin
            board = b[2:0];
            tick(5);
            chk(cfg, {5'h00, board});
            chk({5'h00, pins.oe_n}, 8'h07);
        end
        read_reg(3'h4, 8'h07);
    endtask : t_inputs

    task automatic pulse(input bit is_new);
        res_new  = is_new;
        res_read = !is_new;
        tick(1);
        res_new  = 1'b0;
        res_read = 1'b0;
        tick(3);
    endtask : pulse

    task automatic t_ready();
        write_reg(8'h4C);
        chk({7'h00, pins.out[2]}, 8'h01);
        pulse(1'b1);
        chk({7'h00, rdy}, 8'h01);
        chk({7'h00, pins.out[2]}, 8'h00);
        pulse(1'b0);
        chk({7'h00, rdy}, 8'h00);
        chk({7'h00, pins.out[2]}, 8'h01);
        pulse(1'b1);
        write_reg(8'h44);
        chk({7'h00, pins.out[2]}, 8'h01);
        pulse(1'b0);
    endtask : t_ready

    // Each command recalibrates the rate from its own sync word
    task automatic t_baud_and_misc();
        logic [7:0] a;
        bit         ok;
        int unsigned rates [3] = '{20, 50, 17};
        board = 3'b000;
        foreach (rates[i]) begin
            tpgc_host_model_inst.period = rates[i];
            write_reg(8'h30 | 8'(i + 1));
            read_reg(3'h4, 8'h30 | 8'(i + 1));
        end
        tpgc_host_model_inst.command(8'h4A, 8'h7F, 1'b1, 1'b0, a, ok);
        tick(6);
        chk(cfg, 8'h33);
        read_reg(3'h5, 8'h00);
        tpgc_host_model_inst.command(8'h06, 8'h00, 1'b0, 1'b0, a, ok);
        tick(6);
        chk(cfg, 8'h00);
        chk({5'h00, pins.oe_n}, 8'h07);
    endtask : t_baud_and_misc

    // Enable low freezes every register; a reset in mid-run clears all
    task automatic t_freeze();
        write_reg(8'h12);
        chk({2'b00, pins}, 8'h16);
        board = 3'b111;
        ce    = 1'b0;
        tick(8);
        chk(cfg, 8'h10);
        ce    = 1'b1;
        tick(5);
        chk(cfg, 8'h16);
        rst   = 1'b1;
        tick(2);
        rst   = 1'b0;
        chk(cfg, 8'h00);
        chk({2'b00, pins}, 8'h07);
        tick(6);
        read_reg(3'h4, 8'h07);
    endtask : t_freeze

    // =================================================================
    // Main sequence
    initial begin
        rst      = 1'b1;
        ce       = 1'b1;
        res_new  = 1'b0;
        res_read = 1'b0;
        board    = 3'b000;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        tick(6);
        t_reset();
        t_reserved();
        t_directions();
        t_inputs();
        t_ready();
        t_baud_and_misc();
        t_freeze();
        final_report();
    end

endmodule : tb_top
